// ### logic/kst_keyboard.v
// Keystroke encoder, typematic repeat and queued byte output
`timescale 1ns/1ns
`default_nettype none
`include "kst_regs.vh"

// Notes on behaviour
// - Every key press that fits in the queue is reported, codes leave in press order.
// - While the host does not accept data, codes wait in the queue.
// - The queue is a sixteen-byte first-in-first-out store.
// - A byte that would be seventeenth becomes the overrun marker; with the queue full, the sixteenth byte is overwritten instead.
// - Keystrokes arriving while the queue is full are dropped.
// - When sending resumes, a pending response goes first, then queued bytes, then new codes.
// - Response codes bypass the queue and take none of its slots.
// - A multi-byte sequence is queued only whole, else overrun.
// - Keys other than Pause give make on press and break on release.
// - Break is make with F0 before its last byte.
// - Held key other than Pause: make, 500 ms delay, then repeats at 10.9 per second.
// - Only the most recently pressed key other than Pause repeats.
// - Releasing that key stops repeat; older held keys do not resume.
// - While inhibited, a held key queues no repeat copies.
// - The overrun marker is the byte FF.
// - The marker is sent in its normal place in the queue.
// - Host holding the clock line low inhibits sending; only queue.

module kst_keyboard #(
	parameter [`KST_TMR_W-1:0] REP_DELAY_CYC =
		`KST_DELAY_MS * `KST_CLK_KHZ,
	parameter [`KST_TMR_W-1:0] REP_RATE_CYC =
		(`KST_CLK_KHZ * 10000) / `KST_RATE_X10
) (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire link_clk_i,
	input wire ev_valid,
	output wire ev_ready,
	input wire ev_press,
	input wire ev_ext,
	input wire ev_pause,
	input wire [`KST_DATA_W-1:0] ev_code,
	input wire resp_valid,
	output wire resp_ready,
	input wire [`KST_DATA_W-1:0] resp_code,
	output wire tx_valid,
	input wire tx_ready,
	output wire [`KST_DATA_W-1:0] tx_data,
	output wire inhibited,
	output wire overrun
);

	localparam [0:0] ST_IDLE = 1'b0;
	localparam [0:0] ST_WRITE = 1'b1;
	// Queue depth cut to the count width on purpose
	localparam [31:0] DEPTH_WIDE = `KST_FIFO_DEPTH;
	localparam [`KST_CNT_W-1:0] DEPTH_CNT = DEPTH_WIDE[`KST_CNT_W-1:0];

	// Link clock line synchroniser
	reg lclk_meta_q;
	reg lclk_sync_q;

	// Sequence writer
	reg state_q;
	reg [`KST_DATA_W-1:0] seq1_q;
	reg [`KST_DATA_W-1:0] seq2_q;
	reg [`KST_LEN_W-1:0] len_q;
	reg [`KST_SEL_W-1:0] idx_q;
	reg ovr_q;

	// Typematic state
	reg rep_on_q;
	reg rep_req_q;
	reg rep_ext_q;
	reg [`KST_DATA_W-1:0] rep_code_q;
	reg [`KST_TMR_W-1:0] tmr_q;

	// Output stage
	reg tx_valid_q;
	reg [`KST_DATA_W-1:0] tx_data_q;
	reg resp_pend_q;
	reg [`KST_DATA_W-1:0] resp_q;

	// Decision in idle
	reg take_ev;
	reg take_rep;
	reg n_ext;
	reg n_brk;
	reg n_emit;
	reg [`KST_DATA_W-1:0] n_code;
	reg [`KST_LEN_W-1:0] n_len;

	wire [`KST_CNT_W-1:0] f_count;
	wire f_empty;
	wire f_full;
	wire [`KST_DATA_W-1:0] f_rd_data;
	wire [`KST_CNT_W-1:0] f_free;
	wire fits;
	reg f_wr;
	reg f_ovw;
	reg [`KST_DATA_W-1:0] f_wdata;
	wire f_rd;
	wire load_slot;

	// Number of bytes in a keystroke sequence
	function [`KST_LEN_W-1:0] seq_len;
		input ext;
		input brk;
		begin
			if (ext && brk) begin
				seq_len = `KST_LEN_THREE;
			end else if (ext || brk) begin
				seq_len = `KST_LEN_TWO;
			end else begin
				seq_len = `KST_LEN_ONE;
			end
		end
	endfunction

	// Bytes of the sequence, in order of transmission
	function [`KST_DATA_W-1:0] seq_byte;
		input [`KST_SEL_W-1:0] sel;
		input ext;
		input brk;
		input [`KST_DATA_W-1:0] code;
		begin
			case ({ext, brk})
			2'b11: seq_byte = (sel == 2'h0) ? `KST_EXT_PREFIX :
				(sel == 2'h1) ? `KST_BRK_PREFIX : code;
			2'b10: seq_byte = (sel == 2'h0) ? `KST_EXT_PREFIX : code;
			2'b01: seq_byte = (sel == 2'h0) ? `KST_BRK_PREFIX : code;
			default: seq_byte = code;
			endcase
		end
	endfunction

	always @(posedge clk) begin
		if (srst) begin
			lclk_meta_q <= 1'b1;
			lclk_sync_q <= 1'b1;
		end else if (ce) begin
			lclk_meta_q <= link_clk_i;
			lclk_sync_q <= lclk_meta_q;
		end
	end

	assign inhibited = !lclk_sync_q;
	assign overrun = ovr_q;
	assign ev_ready = (state_q == ST_IDLE);
	assign resp_ready = !resp_pend_q;
	assign f_free = DEPTH_CNT - f_count;
	assign fits = (f_free >= {{(`KST_CNT_W-`KST_LEN_W){1'b0}}, n_len});

	// Pick a key event, else a pending repeat; decide queue action
	always @* begin
		take_ev = 1'b0;
		take_rep = 1'b0;
		n_ext = ev_ext;
		n_brk = !ev_press;
		n_code = ev_code;
		n_emit = 1'b0;
		if (state_q == ST_IDLE) begin
			if (ev_valid) begin
				take_ev = 1'b1;
				n_emit = ev_press || !ev_pause;
			end else if (rep_req_q) begin
				take_rep = 1'b1;
				n_ext = rep_ext_q;
				n_brk = 1'b0;
				n_code = rep_code_q;
				n_emit = 1'b1;
			end
		end
		n_len = seq_len(n_ext, n_brk);
	end

	// Queue write port: whole sequences or one overrun marker
	always @* begin
		f_wr = 1'b0;
		f_ovw = 1'b0;
		f_wdata = seq_byte(idx_q, seq2_q[0], seq2_q[1], seq1_q);
		if (state_q == ST_WRITE) begin
			f_wr = 1'b1;
		end else if (n_emit && !fits && !ovr_q) begin
			if (f_full) begin
				f_ovw = 1'b1;
			end else begin
				f_wr = 1'b1;
				f_wdata = `KST_OVR_CODE;
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			seq1_q <= {`KST_DATA_W{1'b0}};
			seq2_q <= {`KST_DATA_W{1'b0}};
			len_q <= `KST_LEN_ONE;
			idx_q <= {`KST_SEL_W{1'b0}};
			ovr_q <= 1'b0;
		end else if (ce) begin
			if (f_rd) begin
				ovr_q <= 1'b0;
			end
			case (state_q)
			ST_IDLE: begin
				if (n_emit && fits) begin
					seq1_q <= n_code;
					seq2_q <= {6'h00, n_brk, n_ext};
					len_q <= n_len;
					idx_q <= {`KST_SEL_W{1'b0}};
					state_q <= ST_WRITE;
				end else if (n_emit && !ovr_q) begin
					ovr_q <= 1'b1;
				end
			end
			ST_WRITE: begin
				if (idx_q == len_q - `KST_LEN_ONE) begin
					state_q <= ST_IDLE;
				end else begin
					idx_q <= idx_q + 2'h1;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Typematic timer, tracking only the newest pressed key other than Pause
	always @(posedge clk) begin
		if (srst) begin
			rep_on_q <= 1'b0;
			rep_req_q <= 1'b0;
			rep_ext_q <= 1'b0;
			rep_code_q <= {`KST_DATA_W{1'b0}};
			tmr_q <= {`KST_TMR_W{1'b0}};
		end else if (ce) begin
			if (take_rep) begin
				rep_req_q <= 1'b0;
			end
			if (rep_on_q) begin
				if (tmr_q == {`KST_TMR_W{1'b0}}) begin
					tmr_q <= REP_RATE_CYC - 24'h1;
					if (!inhibited) begin
						rep_req_q <= 1'b1;
					end
				end else begin
					tmr_q <= tmr_q - 24'h1;
				end
			end
			if (take_ev && ev_press && !ev_pause) begin
				rep_on_q <= 1'b1;
				rep_req_q <= 1'b0;
				rep_ext_q <= ev_ext;
				rep_code_q <= ev_code;
				tmr_q <= REP_DELAY_CYC - 24'h1;
			end else if (take_ev && !ev_press && ev_ext == rep_ext_q &&
				ev_code == rep_code_q) begin
				rep_on_q <= 1'b0;
				rep_req_q <= 1'b0;
			end
		end
	end

	// Output slot: responses first, then queue head, never while inhibited
	assign load_slot = ce && !inhibited && (!tx_valid_q || tx_ready);
	assign f_rd = load_slot && !resp_pend_q && !f_empty;

	always @(posedge clk) begin
		if (srst) begin
			tx_valid_q <= 1'b0;
			tx_data_q <= {`KST_DATA_W{1'b0}};
			resp_pend_q <= 1'b0;
			resp_q <= {`KST_DATA_W{1'b0}};
		end else if (ce) begin
			if (resp_valid && !resp_pend_q) begin
				resp_pend_q <= 1'b1;
				resp_q <= resp_code;
			end
			if (tx_valid_q && tx_ready) begin
				tx_valid_q <= 1'b0;
			end
			if (load_slot) begin
				if (resp_pend_q) begin
					tx_valid_q <= 1'b1;
					tx_data_q <= resp_q;
					resp_pend_q <= 1'b0;
				end else if (!f_empty) begin
					tx_valid_q <= 1'b1;
					tx_data_q <= f_rd_data;
				end
			end
		end
	end

	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;

	kst_fifo u_fifo (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.wr_en(f_wr),
		.ovw_en(f_ovw),
		.wr_data(f_wdata),
		.rd_en(f_rd),
		.rd_data(f_rd_data),
		.count(f_count),
		.empty(f_empty),
		.full(f_full)
	);

endmodule // kst_keyboard

`default_nettype wire

// ### include/kst_regs.vh
// Constants for the keystroke queue and typematic block
`ifndef KST_REGS_VH
`define KST_REGS_VH

// Queue geometry
`define KST_FIFO_DEPTH 16
`define KST_PTR_W 4
`define KST_CNT_W 5
`define KST_DATA_W 8

// Code bytes
`define KST_OVR_CODE 8'hFF
`define KST_BRK_PREFIX 8'hF0
`define KST_EXT_PREFIX 8'hE0

// Timing: typematic delay in ms, rate in tenths of codes per second
`define KST_CLK_KHZ 25000
`define KST_DELAY_MS 500
`define KST_RATE_X10 109
`define KST_TMR_W 24

// Sequence bookkeeping
`define KST_LEN_W 2
`define KST_LEN_ONE 2'h1
`define KST_LEN_TWO 2'h2
`define KST_LEN_THREE 2'h3
`define KST_SEL_W 2

`endif

// ### logic/kst_fifo.v
// Sixteen-byte flop FIFO with overwrite of the newest entry
`timescale 1ns/1ns
`default_nettype none
`include "kst_regs.vh"

module kst_fifo (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire wr_en,
	input wire ovw_en,
	input wire [`KST_DATA_W-1:0] wr_data,
	input wire rd_en,
	output wire [`KST_DATA_W-1:0] rd_data,
	output wire [`KST_CNT_W-1:0] count,
	output wire empty,
	output wire full
);

	reg [`KST_DATA_W-1:0] mem_q [0:`KST_FIFO_DEPTH-1];
	reg [`KST_PTR_W-1:0] wr_ptr_q;
	reg [`KST_PTR_W-1:0] rd_ptr_q;
	reg [`KST_CNT_W-1:0] cnt_q;
	wire do_wr;
	wire do_rd;
	wire [`KST_PTR_W-1:0] last_ptr;

	// Depth cut to the count width on purpose
	localparam [31:0] DEPTH_WIDE = `KST_FIFO_DEPTH;
	localparam [`KST_CNT_W-1:0] DEPTH_CNT = DEPTH_WIDE[`KST_CNT_W-1:0];

	assign empty = (cnt_q == {`KST_CNT_W{1'b0}});
	assign full = (cnt_q == DEPTH_CNT);
	assign count = cnt_q;
	assign rd_data = mem_q[rd_ptr_q];
	assign do_wr = wr_en && !full;
	assign do_rd = rd_en && !empty;
	assign last_ptr = wr_ptr_q - {{(`KST_PTR_W-1){1'b0}}, 1'b1};

	// Storage has no reset; pointers and count define what is valid
	always @(posedge clk) begin
		if (ce) begin
			if (do_wr) begin
				mem_q[wr_ptr_q] <= wr_data;
			end else if (ovw_en && !empty) begin
				mem_q[last_ptr] <= `KST_OVR_CODE;
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wr_ptr_q <= {`KST_PTR_W{1'b0}};
			rd_ptr_q <= {`KST_PTR_W{1'b0}};
			cnt_q <= {`KST_CNT_W{1'b0}};
		end else if (ce) begin
			if (do_wr) begin
				wr_ptr_q <= wr_ptr_q + {{(`KST_PTR_W-1){1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rd_ptr_q <= rd_ptr_q + {{(`KST_PTR_W-1){1'b0}}, 1'b1};
			end
			if (do_wr && !do_rd) begin
				cnt_q <= cnt_q + {{(`KST_CNT_W-1){1'b0}}, 1'b1};
			end else if (do_rd && !do_wr) begin
				cnt_q <= cnt_q - {{(`KST_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // kst_fifo

`default_nettype wire

// ### testbench/kst_keyboard_chk.sv
// Port assertions for the keystroke queue block
`timescale 1ns/1ns
`default_nettype none
`include "kst_regs.vh"
module kst_keyboard_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic link_clk_i,
	input wire logic ev_valid,
	input wire logic ev_ready,
	input wire logic ev_press,
	input wire logic ev_ext,
	input wire logic ev_pause,
	input wire logic [`KST_DATA_W-1:0] ev_code,
	input wire logic resp_valid,
	input wire logic resp_ready,
	input wire logic [`KST_DATA_W-1:0] resp_code,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [`KST_DATA_W-1:0] tx_data,
	input wire logic inhibited,
	input wire logic overrun
);
	a_tx_holds: assert property (@(posedge clk) disable iff (srst)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte moved before acceptance");
	a_rst_idle: assert property (@(posedge clk)
		srst |=> !tx_valid && !overrun && ev_ready)
		else $error("not idle after reset");
	a_no_load: assert property (@(posedge clk) disable iff (srst)
		inhibited && !tx_valid |=> !tx_valid)
		else $error("byte loaded while inhibited");
	a_inh_set: assert property (@(posedge clk) disable iff (srst)
		!link_clk_i [*3] |=> inhibited)
		else $error("low clock line not seen");
	a_inh_clr: assert property (@(posedge clk) disable iff (srst)
		link_clk_i [*3] |=> !inhibited)
		else $error("inhibit stuck");
	a_ovr_keep: assert property (@(posedge clk) disable iff (srst)
		overrun && inhibited |=> overrun)
		else $error("overrun cleared while inhibited");
	a_resp_load: assert property (@(posedge clk) disable iff (srst)
		!resp_ready && !inhibited && !tx_valid |=> tx_valid && resp_ready)
		else $error("response not loaded");
	a_brk_len: assert property (@(posedge clk) disable iff (srst)
		ev_valid && ev_ready && ev_ext && !ev_press && !ev_pause
		##1 !ev_ready |-> !ev_ready [*3] ##1 ev_ready)
		else $error("break length wrong");
endmodule // kst_keyboard_chk
`default_nettype wire

// ### testbench/kst_host_mdl.sv
// Host model: clock-line inhibit and byte acceptance
`timescale 1ns/1ns
`default_nettype none
module kst_host_mdl (
	input wire logic clk,
	input wire logic inh,
	input wire logic tx_valid,
	output var logic link_clk,
	output var logic tx_ready
);
	logic [7:0] lf_q = 8'h5A;
	initial link_clk = 1'h1;
	initial tx_ready = 1'h0;
	// Line pulled low off the clock grid; still outside frames
	always @(inh) link_clk <= #7 !inh;
	// Serializer takes each byte after a random stall
	always @(posedge clk) begin
		lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
		tx_ready <= tx_valid && !tx_ready && lf_q[0];
	end
endmodule // kst_host_mdl
`default_nettype wire

// ### testbench/kst_keyboard_tb.sv
// Bench: queue model against the keystroke block
`timescale 1ns/1ns
`default_nettype none
`include "kst_regs.vh"
module kst_keyboard_tb;
	logic clk = 0, srst = 1, ce = 1, inh = 0, ovr_m = 0;
	logic ev_valid = 0, ev_press = 0, ev_ext = 0, ev_pause = 0;
	logic resp_valid = 0;
	logic [7:0] ev_code = 8'h00, resp_code = 8'h00;
	logic [7:0] exp_q[$];
	logic [31:0] rs = 32'h451F4782;
	integer error_cnt = 0, n_tests = 0, cnt_m = 0, i;
	wire logic link_clk_i, ev_ready, resp_ready, tx_valid, tx_ready;
	wire logic inhibited, overrun;
	wire logic [7:0] tx_data;
	always #20 clk = ~clk;
	kst_keyboard #(.REP_DELAY_CYC(24'h28), .REP_RATE_CYC(24'h14)) uut (
		.clk(clk), .srst(srst), .ce(ce), .link_clk_i(link_clk_i),
		.ev_valid(ev_valid), .ev_ready(ev_ready), .ev_press(ev_press),
		.ev_ext(ev_ext), .ev_pause(ev_pause), .ev_code(ev_code),
		.resp_valid(resp_valid), .resp_ready(resp_ready),
		.resp_code(resp_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .inhibited(inhibited), .overrun(overrun));
	kst_host_mdl host (.clk(clk), .inh(inh), .tx_valid(tx_valid),
		.link_clk(link_clk_i), .tx_ready(tx_ready));
	function automatic [31:0] xs(input [31:0] s);
		logic [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task automatic chk(input [7:0] seen, exp, input string nm);
		begin
			n_tests++;
			if (seen !== exp) begin
				error_cnt++;
				$display("ERROR %s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task end_sim;
		begin
			$display("tests %0d errors %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Whole sequence if it fits, else one marker per episode, else lost
	task put(input [23:0] s, input integer n);
		integer j;
		begin
			if (cnt_m + n <= 16) begin
				cnt_m += n;
				for (j = n - 1; j >= 0; j--) exp_q.push_back(s[j*8+:8]);
			end else if (!ovr_m) begin
				ovr_m = 1;
				if (cnt_m < 16) exp_q.push_back(8'hFF);
				else exp_q[$] = 8'hFF;
				if (cnt_m < 16) cnt_m++;
			end
		end
	endtask
	task ev(input p, e, z, input [7:0] c);
		begin
			@(posedge clk);
			ev_valid <= 1;
			ev_press <= p;
			ev_ext <= e;
			ev_pause <= z;
			ev_code <= c;
			@(negedge clk);
			while (!ev_ready) @(negedge clk);
			@(posedge clk);
			ev_valid <= 0;
			if (p) put({16'h00E0, c}, e ? 2 : 1);
			else if (!z) put({16'hE0F0, c}, e ? 3 : 2);
		end
	endtask
	task resp(input [7:0] c);
		begin
			@(posedge clk);
			resp_valid <= 1;
			resp_code <= c;
			@(negedge clk);
			while (!resp_ready) @(negedge clk);
			@(posedge clk);
			resp_valid <= 0;
			exp_q.push_back(c);
		end
	endtask
	task drain;
		integer k;
		begin
			@(posedge clk);
			inh <= 0;
			for (k = 0; k < 3000 && exp_q.size(); k++) @(posedge clk);
			repeat (60) @(posedge clk);
			chk(8'(exp_q.size()), 8'h00, "left");
			cnt_m = 0;
			ovr_m = 0;
		end
	endtask
	always @(posedge clk)
		if (tx_valid === 1'h1 && tx_ready === 1'h1)
			chk(tx_data, exp_q.size() ? exp_q.pop_front() : 8'hXX, "tx");
	initial begin
		#400000;
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 0;
		inh <= 1;
		repeat (6) @(posedge clk);
		chk({7'h00, inhibited}, 8'h01, "inh");
		resp(8'hFA);
		for (i = 0; i < 12; i++) begin
			rs = xs(rs);
			ev(1, rs[8], rs[9] & !rs[8], {1'h0, rs[6:0]} | 8'h01);
			ev(0, rs[8], rs[9] & !rs[8], {1'h0, rs[6:0]} | 8'h01);
		end
		chk({7'h00, overrun}, 8'h01, "ovr");
		drain;
		ev(1, 1, 0, 8'h1D);
		repeat (30) @(posedge clk);
		ev(1, 0, 0, 8'h2A);
		for (i = 0; i < 3; i++) put(24'h00002A, 1);
		repeat (90) @(posedge clk);
		ev(0, 0, 0, 8'h2A);
		repeat (90) @(posedge clk);
		ev(0, 1, 0, 8'h1D);
		drain;
		inh <= 1;
		repeat (6) @(posedge clk);
		ev(1, 0, 0, 8'h3B);
		repeat (90) @(posedge clk);
		ev(0, 0, 0, 8'h3B);
		drain;
		end_sim;
	end
endmodule // kst_keyboard_tb
bind kst_keyboard kst_keyboard_chk chk (.clk(clk), .srst(srst), .ce(ce),
	.link_clk_i(link_clk_i), .ev_valid(ev_valid), .ev_ready(ev_ready),
	.ev_press(ev_press), .ev_ext(ev_ext), .ev_pause(ev_pause),
	.ev_code(ev_code), .resp_valid(resp_valid), .resp_ready(resp_ready),
	.resp_code(resp_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_data(tx_data), .inhibited(inhibited), .overrun(overrun));
`default_nettype wire
